// file: rtl/sles_defs.vh
// Register indices, field positions, reset values and widths of the lane error status bank
`ifndef SLES_DEFS_VH
`define SLES_DEFS_VH

// Register indices; the byte address is four times the index
`define SLES_IDX_DISPARITY 12'h46d
`define SLES_IDX_INVALID 12'h46e
`define SLES_IDX_UNEXPECTED 12'h46f
`define SLES_IDX_CGS 12'h470
`define SLES_IDX_FRAME 12'h471
`define SLES_IDX_CHECKSUM 12'h472
`define SLES_IDX_LIMIT 12'h47c
`define SLES_IDX_IRQ_STATUS 12'h480
`define SLES_IDX_IRQ_MASK 12'h481

// Control register fields
`define SLES_BIT_IRQ_CLEAR 7
`define SLES_BIT_COUNTER_OFF 6
`define SLES_BIT_COUNTER_CLEAR 5
`define SLES_LANE_MSB 2

// Interrupt status and mask bit positions
`define SLES_IRQ_DISPARITY 7
`define SLES_IRQ_INVALID 6
`define SLES_IRQ_UNEXPECTED 5
`define SLES_IRQ_CHECKSUM 2
`define SLES_IRQ_FRAME 1
`define SLES_IRQ_CGS 0

// Reset values and counter ceiling
`define SLES_RST_LIMIT 8'h01
`define SLES_RST_MASK 8'h00
`define SLES_CNT_MAX 8'hff

// AXI4-Lite responses
`define SLES_RESP_OKAY 2'b00
`define SLES_RESP_SLVERR 2'b10

`endif

// file: rtl/sles_lane_error_status.v
// Per-lane error counters, sync status and interrupt registers behind an AXI4-Lite slave
//
// Overview of operation
// - Bit 7 clears addressed lane disparity interrupt
// - Bit 6 stops addressed lane disparity counter
// - Bit 5 zeroes addressed lane disparity counter
// - Bits 2:0 select lane for actions
// - Bit 7 clears invalid/unexpected lane interrupt
// - Bit 6 stops invalid/unexpected lane counter
// - Bit 5 zeroes invalid/unexpected lane counter
// - Invalid-code status: lane count reached limit
// - Unexpected-control status: lane count reached limit
// - Code group lock per lane; bit7 clears
// - Any lane unlocked requests sync
// - Live frame alignment per lane; bit7 clears
// - Frame loss starts resync automatically
// - Checksum match per lane; bit7 clears
// - Disparity status: lane count reached limit
// - Masked error reached drives irq low
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sles_defs.vh"

module sles_lane_error_status (
	input wire clk_i,
	input wire rst_i,
	// AXI4-Lite slave
	input wire [15:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [15:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// Lane receiver logic, same clock
	input wire [7:0] disparity_error_i,
	input wire [7:0] invalid_code_error_i,
	input wire [7:0] unexpected_control_error_i,
	input wire [7:0] code_group_locked_i,
	input wire [7:0] frame_aligned_i,
	input wire [7:0] checksum_matched_i,
	// Toward the transmitter and the system
	output wire sync_request_o,
	output wire resync_start_o,
	output wire irq_n_o
);

	//************************************************************
	// Write channel
	//************************************************************
	reg aw_held_q;
	reg w_held_q;
	reg [11:0] aw_idx_q;
	reg [7:0] wd_q;
	reg wstrb0_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	wire wr_go;
	wire wr_ok;
	reg wr_mapped;

	assign s_axi_awready_o = ~aw_held_q;
	assign s_axi_wready_o = ~w_held_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	// A held write waits for the previous response, so one write at most is in flight
	assign wr_go = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_ok = wr_go & wstrb0_q;

	always @* begin
		case (aw_idx_q)
			`SLES_IDX_DISPARITY, `SLES_IDX_INVALID, `SLES_IDX_UNEXPECTED,
			`SLES_IDX_CGS, `SLES_IDX_FRAME, `SLES_IDX_CHECKSUM,
			`SLES_IDX_LIMIT, `SLES_IDX_IRQ_STATUS, `SLES_IDX_IRQ_MASK: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_idx_q <= 12'h000;
			wd_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `SLES_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && !aw_held_q) begin
				aw_held_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr_i[13:2];
			end
			if (s_axi_wvalid_i && !w_held_q) begin
				w_held_q <= 1'b1;
				wd_q <= s_axi_wdata_i[7:0];
				wstrb0_q <= s_axi_wstrb_i[0];
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? `SLES_RESP_OKAY : `SLES_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	//************************************************************
	// One-cycle write strobes per register
	//************************************************************
	wire [2:0] ctl_hit;
	wire hit_cgs;
	wire hit_frame;
	wire hit_chk;
	wire hit_status;
	wire [2:0] type_clear;

	assign ctl_hit[0] = wr_ok & (aw_idx_q == `SLES_IDX_DISPARITY);
	assign ctl_hit[1] = wr_ok & (aw_idx_q == `SLES_IDX_INVALID);
	assign ctl_hit[2] = wr_ok & (aw_idx_q == `SLES_IDX_UNEXPECTED);
	assign hit_cgs = wr_ok & (aw_idx_q == `SLES_IDX_CGS) & wd_q[`SLES_BIT_IRQ_CLEAR];
	assign hit_frame = wr_ok & (aw_idx_q == `SLES_IDX_FRAME) & wd_q[`SLES_BIT_IRQ_CLEAR];
	assign hit_chk = wr_ok & (aw_idx_q == `SLES_IDX_CHECKSUM) & wd_q[`SLES_BIT_IRQ_CLEAR];
	assign hit_status = wr_ok & (aw_idx_q == `SLES_IDX_IRQ_STATUS);
	// A type bit written to the status word clears that type on every lane
	assign type_clear[0] = hit_status & wd_q[`SLES_IRQ_DISPARITY];
	assign type_clear[1] = hit_status & wd_q[`SLES_IRQ_INVALID];
	assign type_clear[2] = hit_status & wd_q[`SLES_IRQ_UNEXPECTED];

	//************************************************************
	// Limit and mask
	//************************************************************
	reg [7:0] limit_q;
	reg [7:0] mask_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			limit_q <= `SLES_RST_LIMIT;
			mask_q <= `SLES_RST_MASK;
		end else begin
			if (wr_ok && aw_idx_q == `SLES_IDX_LIMIT) begin
				limit_q <= wd_q;
			end
			if (wr_ok && aw_idx_q == `SLES_IDX_IRQ_MASK) begin
				mask_q <= wd_q;
			end
		end
	end

	//************************************************************
	// Error counters, three types by eight lanes
	//************************************************************
	wire [23:0] err_in;
	wire [23:0] reached;
	wire [23:0] lane_irq;

	assign err_in = {unexpected_control_error_i, invalid_code_error_i, disparity_error_i};

	genvar t;
	genvar l;
	generate
		for (t = 0; t < 3; t = t + 1) begin : g_type
			for (l = 0; l < 8; l = l + 1) begin : g_lane
				reg [7:0] cnt_q;
				reg off_q;
				reg reached_q;
				reg irq_q;
				wire act;
				wire now_reached;

				assign act = ctl_hit[t] & (wd_q[`SLES_LANE_MSB:0] == l);
				// A limit of zero counts as reached straight away
				assign now_reached = (cnt_q >= limit_q);
				assign reached[t*8+l] = now_reached;
				assign lane_irq[t*8+l] = irq_q;

				always @(posedge clk_i) begin
					if (rst_i) begin
						cnt_q <= 8'h00;
						off_q <= 1'b0;
						reached_q <= 1'b0;
						irq_q <= 1'b0;
					end else begin
						if (act && wd_q[`SLES_BIT_COUNTER_CLEAR]) begin
							cnt_q <= 8'h00;
						end else if (err_in[t*8+l] && !off_q && cnt_q != `SLES_CNT_MAX) begin
							// Saturates so a flood of errors cannot wrap below the limit
							cnt_q <= cnt_q + 8'h01;
						end
						if (act) begin
							// Writing 0 to the off bit re-enables the counter
							off_q <= wd_q[`SLES_BIT_COUNTER_OFF];
						end
						reached_q <= now_reached;
						if (now_reached && !reached_q) begin
							irq_q <= 1'b1;
						end else if ((act && wd_q[`SLES_BIT_IRQ_CLEAR]) || type_clear[t]) begin
							irq_q <= 1'b0;
						end
					end
				end
			end
		end
	endgenerate

	//************************************************************
	// Sync flags and interrupt vector
	//************************************************************
	// Previous levels reset low, so lanes already down at release raise no event
	reg [7:0] cgs_prev_q;
	reg [7:0] frame_prev_q;
	reg [7:0] chk_prev_q;
	reg [2:0] vec_q;
	reg sync_req_q;
	reg resync_q;
	reg irq_n_q;
	wire cgs_lost;
	wire frame_lost;
	wire chk_bad;
	wire [7:0] irq_status;

	assign cgs_lost = |(cgs_prev_q & ~code_group_locked_i);
	assign frame_lost = |(frame_prev_q & ~frame_aligned_i);
	assign chk_bad = |(chk_prev_q & ~checksum_matched_i);
	// Status bits sit at the positions of their mask bits
	assign irq_status = {|lane_irq[7:0], |lane_irq[15:8], |lane_irq[23:16], 2'b00, vec_q};

	always @(posedge clk_i) begin
		if (rst_i) begin
			cgs_prev_q <= 8'h00;
			frame_prev_q <= 8'h00;
			chk_prev_q <= 8'h00;
			vec_q <= 3'b000;
		end else begin
			cgs_prev_q <= code_group_locked_i;
			frame_prev_q <= frame_aligned_i;
			chk_prev_q <= checksum_matched_i;
			// New loss events win over a clear in the same cycle
			if (cgs_lost) begin
				vec_q[`SLES_IRQ_CGS] <= 1'b1;
			end else if (hit_cgs || (hit_status && wd_q[`SLES_IRQ_CGS])) begin
				vec_q[`SLES_IRQ_CGS] <= 1'b0;
			end
			if (frame_lost) begin
				vec_q[`SLES_IRQ_FRAME] <= 1'b1;
			end else if (hit_frame || (hit_status && wd_q[`SLES_IRQ_FRAME])) begin
				vec_q[`SLES_IRQ_FRAME] <= 1'b0;
			end
			if (chk_bad) begin
				vec_q[`SLES_IRQ_CHECKSUM] <= 1'b1;
			end else if (hit_chk || (hit_status && wd_q[`SLES_IRQ_CHECKSUM])) begin
				vec_q[`SLES_IRQ_CHECKSUM] <= 1'b0;
			end
		end
	end

	//************************************************************
	// Requests toward the transmitter
	//************************************************************
	// Held high from reset until every lane is locked, so the far end keeps
	// sending code group characters meanwhile
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync_req_q <= 1'b1;
			resync_q <= 1'b0;
		end else begin
			sync_req_q <= ~&code_group_locked_i;
			// One pulse per fall; a lane that stays down does not retrigger
			resync_q <= frame_lost;
		end
	end

	//************************************************************
	// Interrupt output
	//************************************************************
	// Registered so a glitch on the status or mask path never reaches the pin
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~|(irq_status & mask_q);
		end
	end

	assign sync_request_o = sync_req_q;
	assign resync_start_o = resync_q;
	assign irq_n_o = irq_n_q;

	//************************************************************
	// Read channel
	//************************************************************
	reg rvalid_q;
	reg [7:0] rdata_q;
	reg [1:0] rresp_q;
	reg [7:0] rd_val;
	reg rd_mapped;

	assign s_axi_arready_o = ~rvalid_q;
	assign s_axi_rvalid_o = rvalid_q;
	// Data are captured with the address, so a slow rready still sees a stable word
	assign s_axi_rdata_o = {24'h000000, rdata_q};
	assign s_axi_rresp_o = rresp_q;

	// Control addresses hold no readable action bits; reads give the lane status view
	always @* begin
		rd_val = 8'h00;
		rd_mapped = 1'b1;
		case (s_axi_araddr_i[13:2])
			`SLES_IDX_DISPARITY: begin
				rd_val = reached[7:0];
			end
			`SLES_IDX_INVALID: begin
				rd_val = reached[15:8];
			end
			`SLES_IDX_UNEXPECTED: begin
				rd_val = reached[23:16];
			end
			`SLES_IDX_CGS: begin
				rd_val = code_group_locked_i;
			end
			`SLES_IDX_FRAME: begin
				rd_val = frame_aligned_i;
			end
			`SLES_IDX_CHECKSUM: begin
				rd_val = checksum_matched_i;
			end
			`SLES_IDX_LIMIT: begin
				rd_val = limit_q;
			end
			`SLES_IDX_IRQ_STATUS: begin
				rd_val = irq_status;
			end
			`SLES_IDX_IRQ_MASK: begin
				rd_val = mask_q;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
			rresp_q <= `SLES_RESP_OKAY;
		end else if (s_axi_arvalid_i && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_mapped ? `SLES_RESP_OKAY : `SLES_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: tb/sles_lane_error_status_assertions.sv
// Port checker for the lane error status bank
`timescale 1ns/10ps
`default_nettype none
module sles_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic s_axi_bready_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic [15:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] code_group_locked_i,
	input wire logic [7:0] frame_aligned_i,
	input wire logic sync_request_o,
	input wire logic resync_start_o,
	input wire logic irq_n_o
);
	// *****
	// Checks
	// *****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_sync_on_loss: assert property (
		!$past(rst_i) |-> sync_request_o == ($past(code_group_locked_i) != 8'hff))
		else $error("bad sync request");
	a_resync_on_fall: assert property (
		!$past(rst_i) && |($past(frame_aligned_i) & ~frame_aligned_i) |=> resync_start_o)
		else $error("no resync");
	a_lock_readback: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[13:2] == 12'h470
		|=> s_axi_rdata_o[7:0] == $past(code_group_locked_i))
		else $error("bad lock read");
	a_align_readback: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[13:2] == 12'h471
		|=> s_axi_rdata_o[7:0] == $past(frame_aligned_i))
		else $error("bad align read");
	a_read_answer: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h0)
		else $error("late read");
	a_read_gate: assert property (s_axi_arready_o == !s_axi_rvalid_o)
		else $error("bad arready");
	a_resp_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("bvalid held");
	a_quiet_reset: assert property ($fell(rst_i) |-> irq_n_o && sync_request_o)
		else $error("bad reset state");
	c_resync: cover property (resync_start_o);
	c_sync_req: cover property (sync_request_o);
	c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
endmodule
bind sles_lane_error_status sles_chk u_chk (
	.clk_i, .rst_i, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.code_group_locked_i, .frame_aligned_i, .sync_request_o, .resync_start_o, .irq_n_o
);
`default_nettype wire

// file: tb/sles_tx_model.sv
// Far-end transmitter stand-in: per-lane error pulses and sync levels
`timescale 1ns/10ps
`default_nettype none
module sles_tx_model (
	input wire logic clk_i,
	output var logic [2:0][7:0] err_o,
	output var logic [2:0][7:0] lvl_o
);
	initial begin
		err_o = '0;
		lvl_o = '1;
	end
	// Pulses are spaced apart, as every high cycle counts one error
	task automatic err(input int t, input int l, input int n);
		repeat (n) begin
			@(posedge clk_i);
			err_o[t][l] <= 1'b1;
			@(posedge clk_i);
			err_o[t] <= 8'h00;
		end
	endtask
	task automatic lvl(input int k, input int l, input logic v);
		@(posedge clk_i);
		lvl_o[k][l] <= v;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the lane error status bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] awaddr = '0;
	logic [15:0] araddr = '0;
	logic [7:0] wdata = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire awready, wready, bvalid, arready, rvalid, sync_req, resync, irq_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0][7:0] err, lvl;
	int failures = 0, checks = 0, pulses = 0;
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (resync === 1'b1) pulses <= pulses + 1;
	end
	sles_lane_error_status DUT (
		.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i({24'h0, wdata}), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.disparity_error_i(err[0]), .invalid_code_error_i(err[1]),
		.unexpected_control_error_i(err[2]), .code_group_locked_i(lvl[0]),
		.frame_aligned_i(lvl[1]), .checksum_matched_i(lvl[2]),
		.sync_request_o(sync_req), .resync_start_o(resync), .irq_n_o(irq_n)
	);
	sles_tx_model m (.clk_i(clk_i), .err_o(err), .lvl_o(lvl));
	// *****
	// Bus and report tasks
	// *****
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic results;
		if (failures == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic tmo(input int i);
		if (i == 50) begin
			failures++;
			results();
		end
	endtask
	// Handshakes are judged at the falling edge so they never race the design
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
		int i;
		logic ta, tw, tv;
		logic [1:0] r;
		awaddr <= {2'b00, a, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge clk_i);
			ta = awready;
			tw = wready;
			tv = bvalid;
			r = bresp;
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tv) break;
		end
		bready <= 1'b0;
		// An edge passes so the next request never reassigns a signal in this step
		@(posedge clk_i);
		chk(r, er);
		tmo(i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
		int i;
		logic ta, tv;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= {2'b00, a, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge clk_i);
			ta = arready;
			tv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
			if (tv) break;
		end
		rready <= 1'b0;
		@(posedge clk_i);
		chk(d, {24'h0, e});
		chk(r, er);
		tmo(i);
	endtask
	// *****
	// Scenarios
	// *****
	task automatic t_reset;
		rd(12'h47c, 8'h01);
		rd(12'h481, 8'h00);
		rd(12'h480, 8'h00);
		chk(irq_n, 1'b1);
		chk(sync_req, 1'b0);
		rd(12'h400, 8'h00, 2'b10);
		wr(12'h400, 8'hff, 2'b10);
	endtask
	task automatic t_err;
		int t;
		wr(12'h47c, 8'h02);
		wr(12'h481, 8'he0);
		for (t = 0; t < 3; t++) begin
			m.err(t, t + 3, 1);
			rd(12'h46d + t, 8'h00);
			m.err(t, t + 3, 1);
			rd(12'h46d + t, 8'h08 << t);
			rd(12'h480, 8'h80 >> t);
			chk(irq_n, 1'b0);
			wr(12'h46d + t, 8'h20 | (t + 4));
			rd(12'h46d + t, 8'h08 << t);
			wr(12'h46d + t, 8'h80 | (t + 3));
			rd(12'h480, 8'h00);
			chk(irq_n, 1'b1);
			wr(12'h46d + t, 8'h20 | (t + 3));
			rd(12'h46d + t, 8'h00);
			wr(12'h46d + t, 8'h40 | (t + 3));
			m.err(t, t + 3, 2);
			rd(12'h46d + t, 8'h00);
			wr(12'h46d + t, t + 3);
			m.err(t, t + 3, 2);
			rd(12'h46d + t, 8'h08 << t);
			wr(12'h480, 8'h80 >> t);
			wr(12'h46d + t, 8'h20 | (t + 3));
		end
	endtask
	task automatic t_sync;
		m.lvl(0, 2, 1'b0);
		rd(12'h470, 8'hfb);
		chk(sync_req, 1'b1);
		m.lvl(0, 2, 1'b1);
		m.lvl(1, 1, 1'b0);
		rd(12'h471, 8'hfd);
		chk(pulses, 1);
		m.lvl(1, 1, 1'b1);
		m.lvl(2, 6, 1'b0);
		rd(12'h472, 8'hbf);
		m.lvl(2, 6, 1'b1);
		rd(12'h480, 8'h07);
		chk(irq_n, 1'b1);
		wr(12'h470, 8'h80);
		rd(12'h480, 8'h06);
		wr(12'h471, 8'h80);
		wr(12'h472, 8'h80);
		rd(12'h480, 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_err();
		t_sync();
		results();
	end
endmodule
`default_nettype wire
